/* File: inc/pbw_pkg.sv */
// Purpose: Shared constants and types of the push-button wiper controller.
// Assumes: A 20 MHz system clock and a 1 ms internal time base.
// Notes:   Intervals are counted in time-base ticks of one millisecond.
`default_nettype none
package pbw_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int TIMEBASE_NS   = 1000000;
  localparam int TICK_CYCLES   = TIMEBASE_NS / CLK_PERIOD_NS;
  localparam int DIV_W         = 15;

  localparam int POS_W = 5;
  localparam int TAPS  = 32;
  localparam logic [POS_W-1:0] POS_RESET = 5'h00;
  localparam logic [POS_W-1:0] POS_MIN   = 5'h00;
  localparam logic [POS_W-1:0] POS_MAX   = 5'h1f;
  localparam logic [TAPS-1:0]  TAP_ONE   = 32'h0000_0001;

  // All times below are in milliseconds, one time-base tick each.
  localparam int TIME_W = 11;
  localparam logic [TIME_W-1:0] DEBOUNCE_MS   = 11'h00f;
  localparam logic [TIME_W-1:0] JOIN_MS       = 11'h00f;
  localparam logic [TIME_W-1:0] SLOW_MS       = 11'h0fa;
  localparam logic [TIME_W-1:0] FAST_MS       = 11'h032;
  localparam logic [TIME_W-1:0] FAST_AFTER_MS = 11'h3e8;
  localparam logic [TIME_W-1:0] SHUTDOWN_MS   = 11'h7d0;
  localparam logic [TIME_W-1:0] WAKE_MS       = 11'h0fa;
  localparam logic [TIME_W-1:0] MIN_GAP_MS    = 11'h002;
  localparam int DEB_W = 5;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_PAIR     = 4'h1,
    ST_SLOW     = 4'h2,
    ST_FAST     = 4'h3,
    ST_BOTH     = 4'h4,
    ST_LOCK     = 4'h5,
    ST_SHUT_ARM = 4'h6,
    ST_SHUT     = 4'h7,
    ST_WAKE     = 4'h8
  } pbw_state_t;
endpackage
`default_nettype wire

/* File: inc/pbw_btn_if.sv */
// Purpose: Carries the time base to one button filter and its result back.
// Assumes: One instance per button.
// Notes:   held is the filtered, active-high pressed level.
`default_nettype none
interface pbw_btn_if;
  logic ms_tick;
  logic held;
  modport deb  (input ms_tick, output held);
  modport core (output ms_tick, input held);
endinterface
`default_nettype wire

/* File: hw/pbw_debounce.sv */
// Purpose: Synchronises and debounces one active-low button input.
// Assumes: The ms_tick pulse arrives once per millisecond.
// Notes:   Press needs a steady low; release is taken at once.
`default_nettype none
module pbw_debounce (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic button_n,
  pbw_btn_if.deb    btn
);
  // One extra tick because the first tick may come just after the edge.
  localparam logic [pbw_pkg::DEB_W-1:0] THR =
    pbw_pkg::DEB_W'(pbw_pkg::DEBOUNCE_MS + 11'h001);

  logic                      sync_a;
  logic                      sync_b;
  logic [pbw_pkg::DEB_W-1:0] cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
    end else begin
      sync_a <= button_n;
      sync_b <= sync_a;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (sync_b) begin
      cnt <= '0;
    end else if (btn.ms_tick && cnt != THR) begin
      cnt <= cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      btn.held <= 1'b0;
    end else begin
      btn.held <= !sync_b && (cnt == THR);
    end
  end

  a_press_debounced: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(btn.held) |-> $past(cnt) == THR && !$past(sync_b))
    else $error("Press accepted before the debounce interval.");

  a_release_drop: assert property (
    @(posedge clk) disable iff (!rst_n)
    sync_b |=> !btn.held)
    else $error("Held stayed set after release.");
endmodule
`default_nettype wire

/* File: hw/pbw_wiper_ctrl.sv */
// Purpose: Push-button control of a 32-tap wiper with scan and shutdown.
// Assumes: Button inputs are active low and may be asynchronous to clk.
// Notes:   Outputs lag the wiper counter by one clock.
// Function
// - Power-up loads the wiper counter with tap zero.
// - Up button held past debounce steps one tap upward.
// - Down button held past debounce steps one tap downward.
// - Five-bit counter decoded so exactly one of 32 taps is closed.
// - Low pulses shorter than the debounce interval are ignored.
// - During the first second a held button repeats at slow rate.
// - After one second held, stepping switches to the fast rate.
// - Release stops stepping at once, keeps position, returns to idle.
// - Buttons pressed over 15 ms apart lock out until both released.
// - Both buttons held 2 s opens high terminal, selects lowest tap.
// - Counter saturates at both ends and never wraps.
// - In shutdown a 15 ms single press exits and restores position.
// - Holding on 250 ms after shutdown exit starts auto stepping.
// - Slow scan steps every 250 ms.
// - Fast scan steps every 50 ms.
`default_nettype none
module pbw_wiper_ctrl #(
  parameter int TICK_CYCLES = pbw_pkg::TICK_CYCLES
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       up_button_n,
  input  wire logic                       down_button_n,
  output var  logic [pbw_pkg::TAPS-1:0]   tap_select,
  output var  logic [pbw_pkg::POS_W-1:0]  wiper_pos,
  output var  logic                       high_terminal_on,
  output var  logic                       shutdown
);
  localparam logic [pbw_pkg::DIV_W-1:0] DIV_LAST =
    pbw_pkg::DIV_W'(TICK_CYCLES - 1);

  pbw_btn_if up_if ();
  pbw_btn_if dn_if ();

  logic [pbw_pkg::DIV_W-1:0]  div;
  logic                       tick;
  pbw_pkg::pbw_state_t        state;
  pbw_pkg::pbw_state_t        next_state;
  logic                       dir_up;
  logic                       next_dir;
  logic [pbw_pkg::TIME_W-1:0] tcnt;
  logic [pbw_pkg::TIME_W-1:0] icnt;
  logic                       t_clr;
  logic                       i_clr;
  logic                       step;
  logic                       enter_sd;
  logic                       leave_sd;
  logic                       sd;
  logic [pbw_pkg::POS_W-1:0]  pos;
  logic [pbw_pkg::POS_W-1:0]  saved;
  logic                       up_held;
  logic                       dn_held;
  logic                       own_held;
  logic                       oth_held;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div  <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (div == DIV_LAST);
      div  <= (div == DIV_LAST) ? '0 : div + 1'b1;
    end
  end

  assign up_if.ms_tick = tick;
  assign dn_if.ms_tick = tick;

  pbw_debounce u_up (
    .clk      (clk),
    .rst_n    (rst_n),
    .button_n (up_button_n),
    .btn      (up_if)
  );

  pbw_debounce u_dn (
    .clk      (clk),
    .rst_n    (rst_n),
    .button_n (down_button_n),
    .btn      (dn_if)
  );

  assign up_held  = up_if.held;
  assign dn_held  = dn_if.held;
  assign own_held = dir_up ? up_held : dn_held;
  assign oth_held = dir_up ? dn_held : up_held;

  always_comb begin
    next_state = state;
    next_dir   = dir_up;
    step       = 1'b0;
    t_clr      = 1'b0;
    i_clr      = 1'b0;
    enter_sd   = 1'b0;
    leave_sd   = 1'b0;
    case (state)
      pbw_pkg::ST_IDLE: begin
        if (up_held && dn_held) begin
          next_state = pbw_pkg::ST_BOTH;
          t_clr      = 1'b1;
        end else if (up_held || dn_held) begin
          next_state = pbw_pkg::ST_PAIR;
          next_dir   = up_held;
          t_clr      = 1'b1;
        end
      end
      // single step once the pairing window is settled
      pbw_pkg::ST_PAIR: begin
        if (oth_held) begin
          next_state = pbw_pkg::ST_BOTH;
          t_clr      = 1'b1;
        end else if (!own_held) begin
          step       = 1'b1;
          next_state = pbw_pkg::ST_IDLE;
        end else if (tcnt >= pbw_pkg::JOIN_MS) begin
          step       = 1'b1;
          next_state = pbw_pkg::ST_SLOW;
          i_clr      = 1'b1;
        end
      end
      // slow repeat, switch to fast after one second
      pbw_pkg::ST_SLOW: begin
        if (oth_held) begin
          next_state = pbw_pkg::ST_LOCK;
        end else if (!own_held) begin
          next_state = pbw_pkg::ST_IDLE;
        end else if (tcnt >= pbw_pkg::FAST_AFTER_MS) begin
          next_state = pbw_pkg::ST_FAST;
          i_clr      = 1'b1;
        end else if (icnt >= pbw_pkg::SLOW_MS) begin
          step  = 1'b1;
          i_clr = 1'b1;
        end
      end
      pbw_pkg::ST_FAST: begin
        if (oth_held) begin
          next_state = pbw_pkg::ST_LOCK;
        end else if (!own_held) begin
          next_state = pbw_pkg::ST_IDLE;
        end else if (icnt >= pbw_pkg::FAST_MS) begin
          step  = 1'b1;
          i_clr = 1'b1;
        end
      end
      // both held for the shutdown time
      pbw_pkg::ST_BOTH: begin
        if (!up_held || !dn_held) begin
          next_state = pbw_pkg::ST_LOCK;
        end else if (tcnt >= pbw_pkg::SHUTDOWN_MS) begin
          next_state = pbw_pkg::ST_SHUT_ARM;
          enter_sd   = 1'b1;
        end
      end
      // ignore everything until both are released
      pbw_pkg::ST_LOCK: begin
        if (!up_held && !dn_held) begin
          next_state = pbw_pkg::ST_IDLE;
        end
      end
      pbw_pkg::ST_SHUT_ARM: begin
        if (!up_held && !dn_held) begin
          next_state = pbw_pkg::ST_SHUT;
        end
      end
      // a single debounced press leaves shutdown
      pbw_pkg::ST_SHUT: begin
        if (up_held != dn_held) begin
          next_state = pbw_pkg::ST_WAKE;
          next_dir   = up_held;
          leave_sd   = 1'b1;
          t_clr      = 1'b1;
        end
      end
      // auto stepping after 250 ms more
      pbw_pkg::ST_WAKE: begin
        if (oth_held) begin
          next_state = pbw_pkg::ST_LOCK;
        end else if (!own_held) begin
          next_state = pbw_pkg::ST_IDLE;
        end else if (tcnt >= pbw_pkg::WAKE_MS) begin
          step       = 1'b1;
          next_state = pbw_pkg::ST_SLOW;
          t_clr      = 1'b1;
          i_clr      = 1'b1;
        end
      end
      default: begin
        next_state = pbw_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state  <= pbw_pkg::ST_IDLE;
      dir_up <= 1'b1;
    end else begin
      state  <= next_state;
      dir_up <= next_dir;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tcnt <= '0;
    end else if (t_clr) begin
      tcnt <= '0;
    end else if (tick && tcnt != '1) begin
      tcnt <= tcnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      icnt <= '0;
    end else if (i_clr) begin
      icnt <= '0;
    end else if (tick && icnt != '1) begin
      icnt <= icnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos <= pbw_pkg::POS_RESET;
    end else if (leave_sd) begin
      pos <= saved;
    end else if (step && dir_up && pos != pbw_pkg::POS_MAX) begin
      pos <= pos + 1'b1;
    end else if (step && !dir_up && pos != pbw_pkg::POS_MIN) begin
      pos <= pos - 1'b1;
    end
  end

  // holding register for the pre-shutdown position
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      saved <= pbw_pkg::POS_RESET;
      sd    <= 1'b0;
    end else if (enter_sd) begin
      saved <= pos;
      sd    <= 1'b1;
    end else if (leave_sd) begin
      sd <= 1'b0;
    end
  end

  // one-hot decode; shutdown forces the lowest tap.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tap_select       <= pbw_pkg::TAP_ONE;
      wiper_pos        <= pbw_pkg::POS_RESET;
      high_terminal_on <= 1'b1;
      shutdown         <= 1'b0;
    end else begin
      tap_select       <= sd ? pbw_pkg::TAP_ONE : pbw_pkg::TAP_ONE << pos;
      wiper_pos        <= sd ? pbw_pkg::POS_MIN : pos;
      high_terminal_on <= !sd;
      shutdown         <= sd;
    end
  end

  sequence s_single_held;
    (state == pbw_pkg::ST_SLOW || state == pbw_pkg::ST_FAST) && own_held;
  endsequence

  a_reset_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    !$past(rst_n) |-> pos == pbw_pkg::POS_RESET && !sd)
    else $error("Wiper not at zero after reset.");
  a_tap_onehot: assert property (
    @(posedge clk) disable iff (!rst_n)
    $onehot(tap_select) && tap_select == (pbw_pkg::TAP_ONE << wiper_pos))
    else $error("Tap selection is not one-hot on the wiper position.");
  a_step_up: assert property (
    @(posedge clk) disable iff (!rst_n)
    step && dir_up && pos != pbw_pkg::POS_MAX |=> pos == $past(pos) + 5'h01)
    else $error("Up step did not advance by one tap.");
  a_step_down: assert property (
    @(posedge clk) disable iff (!rst_n)
    step && !dir_up && pos != pbw_pkg::POS_MIN |=> pos == $past(pos) - 5'h01)
    else $error("Down step did not retreat by one tap.");
  a_no_wrap: assert property (
    @(posedge clk) disable iff (!rst_n)
    step && (dir_up ? pos == pbw_pkg::POS_MAX : pos == pbw_pkg::POS_MIN)
    |=> $stable(pos))
    else $error("Counter wrapped at an end.");
  a_release_idle: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state == pbw_pkg::ST_SLOW || state == pbw_pkg::ST_FAST) && !own_held
    && !oth_held |=> state == pbw_pkg::ST_IDLE && $stable(pos))
    else $error("Stepping did not stop on release.");
  a_lock_still: assert property (
    @(posedge clk) disable iff (!rst_n)
    state == pbw_pkg::ST_LOCK |=> $stable(pos))
    else $error("Wiper moved while commands are locked out.");
  a_slow_gap: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_single_held ##0 state == pbw_pkg::ST_SLOW |-> icnt <= pbw_pkg::SLOW_MS)
    else $error("Slow scan interval overrun.");
  a_fast_gap: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_single_held ##0 state == pbw_pkg::ST_FAST |-> icnt <= pbw_pkg::FAST_MS)
    else $error("Fast scan interval overrun.");
  a_fast_after: assert property (
    @(posedge clk) disable iff (!rst_n)
    state == pbw_pkg::ST_SLOW && own_held && !oth_held
    && tcnt >= pbw_pkg::FAST_AFTER_MS |=> state == pbw_pkg::ST_FAST)
    else $error("Fast scan not entered after one second.");
  a_shut_output: assert property (
    @(posedge clk) disable iff (!rst_n)
    enter_sd |=> ##1 !high_terminal_on && tap_select == pbw_pkg::TAP_ONE)
    else $error("Shutdown did not open high terminal and force tap zero.");
  a_shut_restore: assert property (
    @(posedge clk) disable iff (!rst_n)
    leave_sd |=> pos == $past(saved) && !sd)
    else $error("Shutdown exit did not restore the saved position.");
endmodule
`default_nettype wire

/* File: test/pbw_button_pad.sv */
// Purpose: Two push buttons on the far side of the wiper controller.
// Assumes: Press requests change at the falling edge of clk.
// Notes:   A released line goes to its pull-up level, high.
`default_nettype none
module pbw_button_pad #(
  parameter int TICK_CYCLES = 8
) (
  input  wire logic clk,
  input  wire logic want_up,
  input  wire logic want_down,
  output var  logic up_button_n,
  output var  logic down_button_n
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int GAP = int'(pbw_pkg::MIN_GAP_MS) * TICK_CYCLES;
  int up_hi = GAP;
  int dn_hi = GAP;
  initial begin
    up_button_n = 1'b1;
    down_button_n = 1'b1;
  end
  // release gap kept
  // A new press waits until the line has stood high for the gap, so two
  // quick presses are never merged into one by the model.
  always @(negedge clk) begin
    up_hi = up_button_n ? up_hi + 1 : 0;
    dn_hi = down_button_n ? dn_hi + 1 : 0;
    up_button_n <= !(want_up && (!up_button_n || up_hi >= GAP));
    down_button_n <= !(want_down && (!down_button_n || dn_hi >= GAP));
  end
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Purpose: Self-checking bench of the push-button wiper controller.
// Assumes: One time-base tick is shortened to TC clocks.
// Notes:   Step times are logged by a monitor and judged afterwards.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TC = 8;
  localparam int LIMIT = 70000;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        want_up = 1'b0;
  logic        want_down = 1'b0;
  logic        up_button_n;
  logic        down_button_n;
  logic [31:0] tap_select;
  logic [4:0]  wiper_pos;
  logic [4:0]  prev_pos = 5'h00;
  logic        high_terminal_on;
  logic        shutdown;
  logic        mon_on = 1'b0;
  int          errors = 0;
  int          checked = 0;
  int          cycles = 0;
  int          step_t[$];
  logic        one_step;

  always #25 clk = ~clk;

  assign one_step = (wiper_pos - prev_pos) == 5'h01 ||
                    (prev_pos - wiper_pos) == 5'h01;

  pbw_button_pad #(.TICK_CYCLES(TC)) u_pbw_button_pad (
    .clk(clk), .want_up(want_up), .want_down(want_down),
    .up_button_n(up_button_n), .down_button_n(down_button_n));

  pbw_wiper_ctrl #(.TICK_CYCLES(TC)) u_pbw_wiper_ctrl (
    .clk(clk), .rst_n(rst_n), .up_button_n(up_button_n),
    .down_button_n(down_button_n), .tap_select(tap_select),
    .wiper_pos(wiper_pos), .high_terminal_on(high_terminal_on),
    .shutdown(shutdown));

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cmp_val(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_gap(string what, int exp, int got);
    checked++;
    if (got < exp - TC || got > exp + TC) begin
      errors++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic ticks(int n);
    repeat (n * TC) @(negedge clk);
  endtask

  task automatic chk_pos(logic [4:0] p);
    cmp_val("wiper_pos", {27'h0, p}, {27'h0, wiper_pos});
    cmp_val("tap_select", pbw_pkg::TAP_ONE << p, tap_select);
  endtask

  task automatic press(logic up, int n);
    want_up = up;
    want_down = !up;
    ticks(n);
    want_up = 1'b0;
    want_down = 1'b0;
    ticks(10);
  endtask

  // Outputs are read at the falling edge, away from the edge that moves them.
  always @(negedge clk) begin
    cycles++;
    if (rst_n && mon_on && wiper_pos !== prev_pos) begin
      step_t.push_back(cycles);
      cmp_val("step size", 32'h1, {31'h0, one_step});
    end
    prev_pos <= wiper_pos;
    if (cycles == LIMIT) begin
      errors++;
      $display("[ERR] run time expected below %0d seen %0d", LIMIT, cycles);
      summarize();
    end
  end

  task automatic t_reset();
    repeat (20) @(negedge clk);
    chk_pos(5'h00);
    cmp_val("high_terminal_on", 32'h1, {31'h0, high_terminal_on});
    rst_n = 1'b1;
    ticks(1);
    chk_pos(5'h00);
  endtask

  task automatic t_single();
    press(1'b1, 10);
    ticks(40);
    chk_pos(5'h00);
    press(1'b1, 40);
    chk_pos(5'h01);
    press(1'b0, 40);
    chk_pos(5'h00);
    press(1'b0, 40);
    chk_pos(5'h00);
  endtask

  task automatic t_scan();
    step_t.delete();
    mon_on = 1'b1;
    want_up = 1'b1;
    ticks(2700);
    chk_pos(5'h1f);
    cmp_gap("slow gap", 250 * TC, step_t[1] - step_t[0]);
    cmp_gap("slow gap", 250 * TC, step_t[2] - step_t[1]);
    cmp_gap("fast gap", 50 * TC, step_t[30] - step_t[29]);
    cmp_gap("fast gap", 50 * TC, step_t[20] - step_t[19]);
    cmp_gap("fast switch", 1035 * TC, step_t[4] - step_t[0]);
    want_up = 1'b0;
    ticks(300);
    cmp_val("step count", 32'h1f, step_t.size());
    press(1'b0, 40);
    chk_pos(5'h1e);
  endtask

  task automatic t_lock();
    logic [4:0] p;
    want_up = 1'b1;
    ticks(20);
    want_down = 1'b1;
    ticks(30);
    p = wiper_pos;
    ticks(400);
    chk_pos(p);
    want_up = 1'b0;
    want_down = 1'b0;
    ticks(20);
    chk_pos(p);
    press(1'b0, 40);
    chk_pos(p - 5'h01);
  endtask

  task automatic t_shut();
    logic [4:0] q;
    q = wiper_pos;
    mon_on = 1'b0;
    want_up = 1'b1;
    want_down = 1'b1;
    ticks(1990);
    cmp_val("shutdown", 32'h0, {31'h0, shutdown});
    ticks(60);
    cmp_val("shutdown", 32'h1, {31'h0, shutdown});
    cmp_val("high_terminal_on", 32'h0, {31'h0, high_terminal_on});
    chk_pos(5'h00);
    want_up = 1'b0;
    want_down = 1'b0;
    ticks(20);
    cmp_val("shutdown", 32'h1, {31'h0, shutdown});
    want_down = 1'b1;
    ticks(100);
    cmp_val("shutdown", 32'h0, {31'h0, shutdown});
    cmp_val("high_terminal_on", 32'h1, {31'h0, high_terminal_on});
    chk_pos(q);
    ticks(150);
    chk_pos(q);
    ticks(50);
    chk_pos(q - 5'h01);
    want_down = 1'b0;
    ticks(10);
  endtask

  initial begin
    t_reset();
    t_single();
    t_scan();
    t_lock();
    t_shut();
    summarize();
  end
endmodule
`default_nettype wire
